// file: src/csfr_defines.vh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the serial filter register bank files only
`ifndef CSFR_DEFINES_VH
`define CSFR_DEFINES_VH

// ****************************************
// register indices and address width
// ****************************************
`define CSFR_IDX_FMT        8'h09
`define CSFR_IDX_OFS        8'h0a
`define CSFR_IDX_OVF        8'h0b
`define CSFR_IDX_FLT        8'h0c
`define CSFR_IDX_CLKDIR     8'h20
`define CSFR_IDX_STAT       8'h21
`define CSFR_ADDR_W         12

// ****************************************
// field positions
// ****************************************
`define CSFR_FMT_MODE_HI    7
`define CSFR_FMT_MODE_LO    6
`define CSFR_FMT_WLEN_HI    5
`define CSFR_FMT_WLEN_LO    4
`define CSFR_FMT_BCLK256    3
`define CSFR_FMT_DAC_RSYNC  2
`define CSFR_FMT_ADC_RSYNC  1
`define CSFR_FMT_RSYNC_MUTE 0
`define CSFR_CLKDIR_BCLK    7

// ****************************************
// encodings and reset values
// ****************************************
`define CSFR_MODE_I2S       2'h0
`define CSFR_MODE_DSP       2'h1
`define CSFR_MODE_RIGHT     2'h2
`define CSFR_MODE_LEFT      2'h3
`define CSFR_RST_FMT        8'h00
`define CSFR_RST_OFS        8'h00
`define CSFR_RST_PLL_R      4'h1
`define CSFR_RST_FLT        8'h00
`define CSFR_RST_CLKDIR     8'h00
`define CSFR_BCLK_FRAME     9'h100

`endif

// file: src/csfr_ovf_flags.v
// four sticky overflow flags, cleared by a read strobe
// assumes overflow events are pulses on sys_clk_i
`timescale 1ns/100ps
module csfr_ovf_flags (
    // clock and reset
    input  wire       sys_clk_i,
    input  wire       rst_b_i,
    // events and clear
    input  wire [3:0] ovf_set_i,
    input  wire       rd_clr_i,
    // flags
    output wire [3:0] flags_o
);
    reg  [3:0] flags_ff;
    wire [3:0] nxt_flags;

    // set wins over read clear
    assign nxt_flags = (rd_clr_i ? 4'h0 : flags_ff) | ovf_set_i;

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_ff <= 4'h0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags_o = flags_ff;
endmodule // csfr_ovf_flags

// file: src/csfr_regs.v
// apb register bank for serial format, offset, overflow, pll r and filters
// assumes apb master on sys_clk_i and overflow pulses on the same clock
`timescale 1ns/100ps
`include "csfr_defines.vh"

// What this block does
// - format field picks i2s, dsp, right, left
// - word length 16, 20, 24 or 32 bits
// - rate bit only acts in master mode
// - rate bit one gives 256 clocks frame
// - dac resync enable drives dac realign
// - adc resync enable drives adc realign
// - resync mute bit softmutes during realign
// - eight bit offset for send and receive
// - dsp offset counts from word clock rise
// - four sticky overflow flags bits seven-four
// - flag register read clears the flags
// - adc highpass codes select three corners
// - right adc highpass independent, bits five-four
// - dac effects enables left bit3 right bit1
// - dac deemphasis enables left bit2 right bit0
// - bclk direction bit selects master or slave
module csfr_regs (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        rst_b_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // overflow and resync drift events
    input  wire [3:0]  ovf_event_i,
    input  wire        resync_dac_drift_i,
    input  wire        resync_adc_drift_i,
    // serial interface controls
    output reg  [1:0]  xfer_mode_o,
    output reg  [5:0]  word_bits_o,
    output reg         bclk_master_o,
    output reg  [8:0]  bclk_per_frame_o,
    output reg         frame_256_o,
    output reg  [7:0]  data_offset_o,
    output reg         offset_from_wclk_rise_o,
    output reg         dac_resync_o,
    output reg         adc_resync_o,
    output reg         resync_mute_o,
    // pll and filters
    output reg  [4:0]  pll_r_div_o,
    output reg  [1:0]  adc_l_hpf_o,
    output reg  [1:0]  adc_r_hpf_o,
    output reg         dac_l_fx_en_o,
    output reg         dac_r_fx_en_o,
    output reg         dac_l_deemph_en_o,
    output reg         dac_r_deemph_en_o
);

    // ****************************************
    // functions
    // ****************************************
    function [11:0] reg_addr;
        input [7:0] idx;
        begin
            reg_addr = {2'h0, idx, 2'h0};
        end
    endfunction

    function [5:0] wlen_bits;
        input [1:0] code;
        begin
            case (code)
                2'h0:    wlen_bits = 6'h10;
                2'h1:    wlen_bits = 6'h14;
                2'h2:    wlen_bits = 6'h18;
                default: wlen_bits = 6'h20;
            endcase
        end
    endfunction

    // ****************************************
    // register storage
    // ****************************************
    reg  [7:0] fmt_ff;
    reg  [7:0] ofs_ff;
    reg  [3:0] pll_r_ff;
    reg  [7:0] flt_ff;
    reg  [7:0] clkdir_ff;
    wire [3:0] ovf_flags;

    wire acc      = psel_i & penable_i;
    wire wr_en    = acc & pwrite_i;
    wire rd_en    = acc & ~pwrite_i;
    wire hit_fmt  = (paddr_i == reg_addr(`CSFR_IDX_FMT));
    wire hit_ofs  = (paddr_i == reg_addr(`CSFR_IDX_OFS));
    wire hit_ovf  = (paddr_i == reg_addr(`CSFR_IDX_OVF));
    wire hit_flt  = (paddr_i == reg_addr(`CSFR_IDX_FLT));
    wire hit_dir  = (paddr_i == reg_addr(`CSFR_IDX_CLKDIR));
    wire hit_stat = (paddr_i == reg_addr(`CSFR_IDX_STAT));
    wire hit_any  = hit_fmt | hit_ofs | hit_ovf | hit_flt | hit_dir | hit_stat;

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fmt_ff    <= `CSFR_RST_FMT;
            ofs_ff    <= `CSFR_RST_OFS;
            pll_r_ff  <= `CSFR_RST_PLL_R;
            flt_ff    <= `CSFR_RST_FLT;
            clkdir_ff <= `CSFR_RST_CLKDIR;
        end else if (wr_en) begin
            if (hit_fmt) begin
                fmt_ff <= pwdata_i[7:0];
            end else if (hit_ofs) begin
                ofs_ff <= pwdata_i[7:0];
            end else if (hit_ovf) begin
                pll_r_ff <= pwdata_i[3:0];
            end else if (hit_flt) begin
                flt_ff <= pwdata_i[7:0];
            end else if (hit_dir) begin
                clkdir_ff <= {pwdata_i[7], 7'h00};
            end
        end
    end

    // ****************************************
    // overflow flags, cleared by a read
    // ****************************************
    csfr_ovf_flags u_ovf (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .ovf_set_i (ovf_event_i),
        .rd_clr_i  (rd_en & hit_ovf),
        .flags_o   (ovf_flags)
    );

    // ****************************************
    // apb answer, no wait states
    // ****************************************
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = 8'h00;
        if (hit_fmt) begin
            rd_mux = fmt_ff;
        end else if (hit_ofs) begin
            rd_mux = ofs_ff;
        end else if (hit_ovf) begin
            rd_mux = {ovf_flags, pll_r_ff};
        end else if (hit_flt) begin
            rd_mux = flt_ff;
        end else if (hit_dir) begin
            rd_mux = clkdir_ff;
        end else if (hit_stat) begin
            rd_mux = {5'h00, dac_resync_o, adc_resync_o, resync_mute_o};
        end
    end

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_o  <= 32'h0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~hit_any;
            if (psel_i & ~penable_i & ~pwrite_i) begin
                prdata_o <= {24'h0, rd_mux};
            end
        end
    end

    // ****************************************
    // decoded controls
    // ****************************************
    wire       mst     = clkdir_ff[`CSFR_CLKDIR_BCLK];
    wire [1:0] mode    = fmt_ff[`CSFR_FMT_MODE_HI:`CSFR_FMT_MODE_LO];
    wire       use_256 = mst & fmt_ff[`CSFR_FMT_BCLK256];

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            xfer_mode_o             <= `CSFR_MODE_I2S;
            word_bits_o             <= 6'h10;
            bclk_master_o           <= 1'b0;
            bclk_per_frame_o        <= 9'h0;
            frame_256_o             <= 1'b0;
            data_offset_o           <= `CSFR_RST_OFS;
            offset_from_wclk_rise_o <= 1'b0;
            dac_resync_o            <= 1'b0;
            adc_resync_o            <= 1'b0;
            resync_mute_o           <= 1'b0;
            pll_r_div_o             <= 5'h01;
            adc_l_hpf_o             <= 2'h0;
            adc_r_hpf_o             <= 2'h0;
            dac_l_fx_en_o           <= 1'b0;
            dac_r_fx_en_o           <= 1'b0;
            dac_l_deemph_en_o       <= 1'b0;
            dac_r_deemph_en_o       <= 1'b0;
        end else begin
            xfer_mode_o      <= mode;
            word_bits_o      <= wlen_bits(fmt_ff[`CSFR_FMT_WLEN_HI:`CSFR_FMT_WLEN_LO]);
            bclk_master_o    <= mst;
            frame_256_o      <= use_256;
            bclk_per_frame_o <= use_256 ? `CSFR_BCLK_FRAME : 9'h0;
            data_offset_o    <= ofs_ff;
            offset_from_wclk_rise_o <= (mode == `CSFR_MODE_DSP);
            dac_resync_o     <= fmt_ff[`CSFR_FMT_DAC_RSYNC] & resync_dac_drift_i;
            adc_resync_o     <= fmt_ff[`CSFR_FMT_ADC_RSYNC] & resync_adc_drift_i;
            resync_mute_o    <= fmt_ff[`CSFR_FMT_RSYNC_MUTE] &
                                ((fmt_ff[`CSFR_FMT_DAC_RSYNC] & resync_dac_drift_i) |
                                 (fmt_ff[`CSFR_FMT_ADC_RSYNC] & resync_adc_drift_i));
            pll_r_div_o      <= (pll_r_ff == 4'h0) ? 5'h10 : {1'b0, pll_r_ff};
            adc_l_hpf_o      <= flt_ff[7:6];
            adc_r_hpf_o      <= flt_ff[5:4];
            dac_l_fx_en_o    <= flt_ff[3];
            dac_r_fx_en_o    <= flt_ff[1];
            dac_l_deemph_en_o <= flt_ff[2];
            dac_r_deemph_en_o <= flt_ff[0];
        end
    end
endmodule // csfr_regs

// file: tb/csfr_regs_monitor.sv
// port checker for the serial filter register bank
// assumes a bind onto csfr_regs, one clock domain
`timescale 1ns/100ps
// ****************
// checker
// ****************
module csfr_regs_monitor (
    // clock, reset, bus
    input wire        sys_clk_i,
    input wire        rst_b_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    // events and controls
    input wire [3:0]  ovf_event_i,
    input wire        resync_dac_drift_i,
    input wire [5:0]  word_bits_o,
    input wire [1:0]  xfer_mode_o,
    input wire        bclk_master_o,
    input wire [8:0]  bclk_per_frame_o,
    input wire        frame_256_o,
    input wire        offset_from_wclk_rise_o,
    input wire        dac_resync_o,
    input wire        adc_resync_o,
    input wire        resync_mute_o,
    input wire [4:0]  pll_r_div_o
);
    wire rd_ovf = psel_i && !pwrite_i && paddr_i == 12'h02c;
    reg  clean_ff;
    // set after a flag read with no event since
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            clean_ff <= 1'b0;
        else if (ovf_event_i != 4'h0)
            clean_ff <= 1'b0;
        else if (rd_ovf && penable_i && pready_o)
            clean_ff <= 1'b1;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    word_len_a: assert property (word_bits_o inside {6'd16, 6'd20, 6'd24, 6'd32})
        else $error("word length out of range");
    frame_len_a: assert property (bclk_per_frame_o == (frame_256_o ? 9'h100 : 9'h000))
        else $error("bit clocks per frame wrong");
    slave_rate_a: assert property (!bclk_master_o && !$past(bclk_master_o) |-> !frame_256_o)
        else $error("frame mode active in slave");
    dsp_rise_a: assert property ($stable(xfer_mode_o) [*2]
        |-> offset_from_wclk_rise_o == (xfer_mode_o == 2'h1)) else $error("dsp offset origin wrong");
    pll_range_a: assert property (pll_r_div_o >= 5'h01 && pll_r_div_o <= 5'h10)
        else $error("pll r divider out of range");
    dac_drift_a: assert property (dac_resync_o |-> $past(resync_dac_drift_i)
        || $past(resync_dac_drift_i, 2)) else $error("dac resync without drift");
    mute_need_a: assert property (resync_mute_o |-> dac_resync_o || adc_resync_o
        || $past(dac_resync_o || adc_resync_o)) else $error("mute without resync");
    rd_clear_a: assert property (clean_ff && rd_ovf && !penable_i && ovf_event_i == 4'h0
        |=> prdata_o[7:4] == 4'h0) else $error("flags not cleared by read");
    cover property (rd_ovf && penable_i && pready_o && ovf_event_i != 4'h0);
    cover property (frame_256_o);
    cover property (resync_mute_o);
endmodule // csfr_regs_monitor

bind csfr_regs csfr_regs_monitor i_csfr_regs_monitor (.*);

// file: tb/tb_top.sv
// self-checking bench for the serial filter register bank
// assumes csfr_regs with the monitor bound onto it
`timescale 1ns/100ps
// ****************
// bench
// ****************
module tb_top;
    reg         sys_clk_i, rst_b_i, psel_i, penable_i, pwrite_i;
    reg         resync_dac_drift_i, resync_adc_drift_i, se;
    reg  [11:0] paddr_i;
    reg  [31:0] pwdata_i, rd;
    reg  [3:0]  ovf_event_i, p;
    reg  [7:0]  f, o, t, d;
    wire [31:0] prdata_o;
    wire        pready_o, pslverr_o, bclk_master_o, frame_256_o, offset_from_wclk_rise_o;
    wire        dac_resync_o, adc_resync_o, resync_mute_o, lfx, rfx, lde, rde;
    wire [1:0]  xfer_mode_o, lhp, rhp;
    wire [5:0]  word_bits_o;
    wire [8:0]  bclk_per_frame_o;
    wire [7:0]  data_offset_o;
    wire [4:0]  pll_r_div_o;
    integer     err_count, num_checks, cyc, i;
    localparam [319:0] ROWS = {20'h02400, 20'h02454, 20'h024a8, 20'h08080, 20'h024f9,
        20'h02440, 20'h08000, 20'h02810, 20'h0280b, 20'h02c00, 20'h02cf3, 20'h02c0f,
        20'h0305a, 20'h030a5, 20'h030e4, 20'h100ff};
    wire [31:0] obs = {xfer_mode_o, word_bits_o, data_offset_o, pll_r_div_o, lhp, rhp, lfx, lde,
        rfx, rde, offset_from_wclk_rise_o, frame_256_o, bclk_master_o};
    csfr_regs i_csfr_regs (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .ovf_event_i(ovf_event_i), .resync_dac_drift_i(resync_dac_drift_i),
        .resync_adc_drift_i(resync_adc_drift_i), .xfer_mode_o(xfer_mode_o),
        .word_bits_o(word_bits_o), .bclk_master_o(bclk_master_o),
        .bclk_per_frame_o(bclk_per_frame_o), .frame_256_o(frame_256_o),
        .data_offset_o(data_offset_o), .offset_from_wclk_rise_o(offset_from_wclk_rise_o),
        .dac_resync_o(dac_resync_o), .adc_resync_o(adc_resync_o),
        .resync_mute_o(resync_mute_o), .pll_r_div_o(pll_r_div_o), .adc_l_hpf_o(lhp),
        .adc_r_hpf_o(rhp), .dac_l_fx_en_o(lfx), .dac_r_fx_en_o(rfx),
        .dac_l_deemph_en_o(lde), .dac_r_deemph_en_o(rde));
    // expected control outputs from the register copies
    function [31:0] obs_exp();
        reg [5:0] wb;
        begin
            wb = (f[5:4] == 2'h3) ? 6'h20 : 6'h10 + 6'h04 * f[5:4];
            obs_exp = {f[7:6], wb, o, (p == 4'h0) ? 5'h10 : {1'b0, p}, t, f[7:6] == 2'h1,
                d[7] & f[3], d[7]};
        end
    endfunction
    function [7:0] rd_exp(input [11:0] a);
        case (a)
            12'h024: rd_exp = f;
            12'h028: rd_exp = o;
            12'h02c: rd_exp = {4'h0, p};
            12'h030: rd_exp = t;
            12'h080: rd_exp = d;
            default: rd_exp = 8'h00;
        endcase
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task apb(input [11:0] a, input w, input [7:0] wd, input [3:0] ev);
        integer n;
        begin
            n = 0;
            @(posedge sys_clk_i);
            psel_i <= 1'b1;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= {24'h0, wd};
            @(posedge sys_clk_i);
            penable_i <= 1'b1;
            ovf_event_i <= ev;
            do begin
                @(posedge sys_clk_i);
                ovf_event_i <= 4'h0;
                n = n + 1;
            end while (pready_o !== 1'b1 && n < 50);
            rd = prdata_o;
            se = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask
    task row(input [11:0] a, input [7:0] wd);
        begin
            apb(a, 1'b1, wd, 4'h0);
            case (a)
                12'h024: f = wd;
                12'h028: o = wd;
                12'h02c: p = wd[3:0];
                12'h030: t = wd;
                12'h080: d = wd;
            endcase
            apb(a, 1'b0, 8'h00, 4'h0);
            chk(rd, {24'h0, rd_exp(a)});
            chk({31'h0, se}, {31'h0, a == 12'h100});
            repeat (2) @(posedge sys_clk_i);
            chk(obs, obs_exp());
        end
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            err_count = err_count + 1;
            end_sim;
        end
    end
    initial begin
        {rst_b_i, psel_i, penable_i, pwrite_i, resync_dac_drift_i, resync_adc_drift_i} = 6'h0;
        {paddr_i, pwdata_i, ovf_event_i} = 48'h0;
        {err_count, num_checks, cyc} = 0;
        {f, o, t, d, p} = 36'h1;
        repeat (16) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        for (i = 0; i < 16; i = i + 1)
            row(ROWS[(15 - i) * 20 + 8 +: 12], ROWS[(15 - i) * 20 +: 8]);
        $display("register rows done");
        @(posedge sys_clk_i);
        ovf_event_i <= 4'ha;
        @(posedge sys_clk_i);
        ovf_event_i <= 4'h0;
        repeat (5) @(posedge sys_clk_i);
        apb(12'h02c, 1'b0, 8'h00, 4'h5);
        chk(rd, {24'h0, 4'ha, p});
        apb(12'h02c, 1'b0, 8'h00, 4'h0);
        chk(rd, {24'h0, 4'h5, p});
        apb(12'h02c, 1'b0, 8'h00, 4'h0);
        chk(rd, {24'h0, 4'h0, p});
        $display("overflow flags done");
        row(12'h024, 8'h07);
        resync_dac_drift_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        chk({dac_resync_o, adc_resync_o, resync_mute_o}, 3'h5);
        resync_dac_drift_i <= 1'b0;
        resync_adc_drift_i <= 1'b1;
        row(12'h024, 8'h06);
        chk({dac_resync_o, adc_resync_o, resync_mute_o}, 3'h2);
        resync_adc_drift_i <= 1'b0;
        $display("resync done");
        rst_b_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        {f, o, t, d, p} = 36'h1;
        chk(obs, obs_exp());
        for (i = 9; i < 13; i = i + 1) begin
            apb(i * 4, 1'b0, 8'h00, 4'h0);
            chk(rd, {24'h0, rd_exp(i * 4)});
        end
        $display("reset values done");
        end_sim;
    end
endmodule // tb_top
